// ### design/uart_pkg.sv
// How it works
// - Full duplex, variable-rate 8-bit and 9-bit only
// - Data buffer writes load transmit register when transmitter idle
// - Data buffer reads return receive buffer
// - Receive shifter separate from receive buffer
// - Completion flags cleared only by software
// - Interrupt on either flag when enabled
// - Transmit bit clock from timer overflows
// - Hidden receive timer mirrors timer, same reload
// - Start edge forces receive timer reload
// - Overflows halved; period 256 minus reload
// - Software sets timer rate and clock source
// - Control bit 7 selects framing
// - 8-bit: start, 8 data LSB first, stop
// - 8-bit: stop bit into received ninth bit
// - Write starts sending; flag at stop start
// - Receive only when enable bit set
// - 8-bit load needs flag clear, filtered stop
// - Overrun keeps old buffer, drops new character
// - 9-bit: start, data, ninth bit, stop
// - 9-bit: ninth bit stored, stop ignored
// - 9-bit load needs flag clear, filtered ninth
// - Master marks address bytes with ninth bit
package uart_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_BUFFER  = 8'h04;
   localparam logic [7:0] OFS_RELOAD  = 8'h08;
   localparam logic [7:0] OFS_TIMER   = 8'h0c;
   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int BIT_FRAME_SEL = 7;
   localparam int BIT_UNUSED    = 6;
   localparam int BIT_FILTER    = 5;
   localparam int BIT_RX_EN     = 4;
   localparam int BIT_TX_NINTH  = 3;
   localparam int BIT_RX_NINTH  = 2;
   localparam int BIT_TX_FLAG   = 1;
   localparam int BIT_RX_FLAG   = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h40;
   // ---------------------------------------------------------------
   // Timer register fields
   // ---------------------------------------------------------------
   localparam int BIT_TIMER_RUN = 0;
   localparam int BIT_PRE_LO    = 1;
   localparam int BIT_PRE_HI    = 2;
   localparam int BIT_IRQ_EN    = 3;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] TIMER_TOP    = 8'hff;
   localparam logic [5:0] PRE_DIV1  = 6'h00;
   localparam logic [5:0] PRE_DIV4  = 6'h03;
   localparam logic [5:0] PRE_DIV12 = 6'h0b;
   localparam logic [5:0] PRE_DIV48 = 6'h2f;
   // ---------------------------------------------------------------
   // Frame lengths in bit times, far bit period in clocks
   // ---------------------------------------------------------------
   localparam logic [3:0] FRAME_LEN8 = 4'ha;
   localparam logic [3:0] FRAME_LEN9 = 4'hb;
   localparam logic [15:0] FAR_BIT_CYCLES = 16'h0010;
endpackage

// ### design/uart_link_if.sv
`timescale 1ns/1ps
interface uart_link_if;
   logic dev_to_far;
   logic far_to_dev;
   modport dev (output dev_to_far, input far_to_dev);
   modport far (input dev_to_far, output far_to_dev);
endinterface

// ### design/uart_dev.sv
`timescale 1ns/1ps
module uart_dev (
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   uart_link_if.dev         LINK,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             IRQ
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} tx_state_type;
   typedef enum logic {RX_IDLE, RX_BITS} rx_state_type;
   tx_state_type tx_state_q;
   rx_state_type rx_state_q;
   logic        frame9_q, filter_q, rx_en_q, tx9_q, rx9_q, txf_q, rxf_q;
   logic        run_q, irq_en_q, err_q;
   logic [1:0]  presel_q;
   logic [7:0]  reload_q, tx_tmr_q, rx_tmr_q, rx_buf_q, rx_sh_q, tx_hold_q;
   logic [5:0]  pre_q, pre_top;
   logic        tick, tx_ovf, rx_ovf, tx_half_q, rx_half_q, tx_baud, rx_sample;
   logic [10:0] tx_sh_q;
   logic [3:0]  tx_cnt_q, rx_cnt_q, frame_len;
   logic        in_prev_q, start_seen, rx_v9_q, rx_done, rx_load, rx_bit;
   logic        wr, setup, hit, wr_ctl, wr_buf, tx_flag_set;
   logic [31:0] rd_val, rd_val_q;

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   assign setup = PSEL & ~PENABLE;
   assign wr = PSEL & PENABLE & PWRITE;
   assign wr_ctl = wr && (PADDR == uart_pkg::OFS_CONTROL);
   assign wr_buf = wr && (PADDR == uart_pkg::OFS_BUFFER);
   assign PREADY = 1'b1;
   assign PSLVERR = err_q & PSEL & PENABLE;
   assign PRDATA = rd_val_q;

   always_comb begin
      rd_val = 32'h0000_0000;
      hit = 1'b1;
      if (PADDR == uart_pkg::OFS_CONTROL) begin
         rd_val[7:0] = {frame9_q, 1'b1, filter_q, rx_en_q, tx9_q, rx9_q, txf_q, rxf_q};
      end else if (PADDR == uart_pkg::OFS_BUFFER) begin
         rd_val[7:0] = rx_buf_q; // Transmit data never readable
      end else if (PADDR == uart_pkg::OFS_RELOAD) begin
         rd_val[7:0] = reload_q;
      end else if (PADDR == uart_pkg::OFS_TIMER) begin
         rd_val[3:0] = {irq_en_q, presel_q, run_q};
      end else begin
         hit = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rd_val_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else if (setup) begin
         rd_val_q <= PWRITE ? 32'h0000_0000 : rd_val;
         err_q <= ~hit;
      end
   end

   // ---------------------------------------------------------------
   // Control and timer registers
   // ---------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         frame9_q <= uart_pkg::CONTROL_RESET[uart_pkg::BIT_FRAME_SEL];
         filter_q <= uart_pkg::CONTROL_RESET[uart_pkg::BIT_FILTER];
         rx_en_q  <= uart_pkg::CONTROL_RESET[uart_pkg::BIT_RX_EN];
         tx9_q    <= uart_pkg::CONTROL_RESET[uart_pkg::BIT_TX_NINTH];
         reload_q <= uart_pkg::RELOAD_RESET;
         run_q    <= 1'b0;
         presel_q <= 2'h0;
         irq_en_q <= 1'b0;
      end else begin
         if (wr_ctl) begin
            frame9_q <= PWDATA[uart_pkg::BIT_FRAME_SEL]; // Zero 8-bit, one 9-bit
            filter_q <= PWDATA[uart_pkg::BIT_FILTER];
            rx_en_q  <= PWDATA[uart_pkg::BIT_RX_EN];
            tx9_q    <= PWDATA[uart_pkg::BIT_TX_NINTH];
         end
         if (wr && PADDR == uart_pkg::OFS_RELOAD) begin
            reload_q <= PWDATA[7:0];
         end
         if (wr && PADDR == uart_pkg::OFS_TIMER) begin
            run_q    <= PWDATA[uart_pkg::BIT_TIMER_RUN];
            presel_q <= PWDATA[uart_pkg::BIT_PRE_HI:uart_pkg::BIT_PRE_LO];
            irq_en_q <= PWDATA[uart_pkg::BIT_IRQ_EN];
         end
      end
   end

   // Hardware set beats a software write in the same cycle
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         txf_q <= uart_pkg::CONTROL_RESET[uart_pkg::BIT_TX_FLAG];
         rxf_q <= uart_pkg::CONTROL_RESET[uart_pkg::BIT_RX_FLAG];
         rx9_q <= uart_pkg::CONTROL_RESET[uart_pkg::BIT_RX_NINTH];
      end else begin
         if (tx_flag_set) begin
            txf_q <= 1'b1;
         end else if (wr_ctl) begin
            txf_q <= PWDATA[uart_pkg::BIT_TX_FLAG]; // Only software clears
         end
         if (rx_load) begin
            rxf_q <= 1'b1;
            rx9_q <= rx_bit; // Stop or ninth bit
         end else if (wr_ctl) begin
            rxf_q <= PWDATA[uart_pkg::BIT_RX_FLAG];
            rx9_q <= PWDATA[uart_pkg::BIT_RX_NINTH];
         end
      end
   end

   assign IRQ = irq_en_q & (txf_q | rxf_q);

   // ---------------------------------------------------------------
   // Baud timers
   // ---------------------------------------------------------------
   always_comb begin
      case (presel_q)
         2'h0:    pre_top = uart_pkg::PRE_DIV1;
         2'h1:    pre_top = uart_pkg::PRE_DIV4;
         2'h2:    pre_top = uart_pkg::PRE_DIV12;
         default: pre_top = uart_pkg::PRE_DIV48;
      endcase
   end
   assign tick = run_q && (pre_q == pre_top);
   assign tx_ovf = tick && (tx_tmr_q == uart_pkg::TIMER_TOP);
   assign rx_ovf = tick && (rx_tmr_q == uart_pkg::TIMER_TOP) && !start_seen;
   assign tx_baud = tx_ovf & tx_half_q; // Every second overflow
   assign rx_sample = rx_ovf & ~rx_half_q; // Bit centre, half period after edge

   always_ff @(posedge CLK) begin
      if (SYS_RST || !run_q || tick) begin
         pre_q <= 6'h00;
      end else begin
         pre_q <= pre_q + 6'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         tx_tmr_q <= uart_pkg::RELOAD_RESET;
         tx_half_q <= 1'b0;
      end else if (tick) begin
         tx_tmr_q <= tx_ovf ? reload_q : tx_tmr_q + 8'h01;
         tx_half_q <= tx_half_q ^ tx_ovf;
      end
   end

   // Receive copy resynchronised so its phase is independent of transmit
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rx_tmr_q <= uart_pkg::RELOAD_RESET;
         rx_half_q <= 1'b0;
      end else if (start_seen) begin
         rx_tmr_q <= reload_q;
         rx_half_q <= 1'b0;
      end else if (tick) begin
         rx_tmr_q <= rx_ovf ? reload_q : rx_tmr_q + 8'h01;
         rx_half_q <= rx_half_q ^ rx_ovf;
      end
   end

   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   assign frame_len = frame9_q ? uart_pkg::FRAME_LEN9 : uart_pkg::FRAME_LEN8;
   assign tx_flag_set = tx_baud && tx_state_q == TX_SEND && tx_cnt_q == frame_len - 4'h2;
   assign LINK.dev_to_far = tx_sh_q[0];

   // Writes while a frame is in flight are dropped, not queued
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         tx_state_q <= TX_IDLE;
         tx_sh_q <= 11'h7ff;
         tx_hold_q <= 8'h00;
         tx_cnt_q <= 4'h0;
      end else begin
         case (tx_state_q)
            TX_IDLE: begin
               if (wr_buf) begin
                  tx_hold_q <= PWDATA[7:0];
                  tx_state_q <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               if (tx_baud) begin
                  // Start, data LSB first, ninth or stop, stop
                  tx_sh_q <= {1'b1, frame9_q ? tx9_q : 1'b1, tx_hold_q, 1'b0};
                  tx_cnt_q <= 4'h0;
                  tx_state_q <= TX_SEND;
               end
            end
            default: begin
               if (tx_baud) begin
                  tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                  tx_cnt_q <= tx_cnt_q + 4'h1;
                  if (tx_cnt_q == frame_len - 4'h1) begin
                     tx_state_q <= TX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   assign start_seen = rx_state_q == RX_IDLE && rx_en_q && in_prev_q && !LINK.far_to_dev;
   assign rx_done = rx_sample && rx_state_q == RX_BITS && rx_cnt_q == frame_len - 4'h1;
   assign rx_bit = frame9_q ? rx_v9_q : LINK.far_to_dev;
   // Busy flag keeps the unread byte; the new one is lost
   assign rx_load = rx_done && !rxf_q && (!filter_q || rx_bit);

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         in_prev_q <= 1'b1;
      end else begin
         in_prev_q <= LINK.far_to_dev;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rx_state_q <= RX_IDLE;
         rx_cnt_q <= 4'h0;
         rx_sh_q <= 8'h00;
         rx_v9_q <= 1'b0;
      end else begin
         case (rx_state_q)
            RX_IDLE: begin
               if (start_seen) begin
                  rx_cnt_q <= 4'h0;
                  rx_state_q <= RX_BITS;
               end
            end
            default: begin
               if (rx_sample) begin
                  rx_cnt_q <= rx_cnt_q + 4'h1;
                  if (rx_cnt_q == 4'h0 && LINK.far_to_dev) begin
                     rx_state_q <= RX_IDLE; // Glitch, not a start bit
                  end else if (rx_done) begin
                     rx_state_q <= RX_IDLE;
                  end else if (rx_cnt_q >= 4'h1 && rx_cnt_q <= 4'h8) begin
                     rx_sh_q <= {LINK.far_to_dev, rx_sh_q[7:1]};
                  end else if (rx_cnt_q == 4'h9) begin
                     rx_v9_q <= LINK.far_to_dev; // Ninth bit; stop bit later ignored
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         rx_buf_q <= 8'h00;
      end else if (rx_load) begin
         rx_buf_q <= rx_sh_q;
      end
   end
endmodule // uart_dev

// ### design/uart_far.sv
`timescale 1ns/1ps
module uart_far #(
   parameter logic [15:0] BIT_CYCLES = uart_pkg::FAR_BIT_CYCLES
) (
   input  wire logic       CLK,
   input  wire logic       SYS_RST,
   uart_link_if.far        LINK,
   input  wire logic       NINE_BIT,
   input  wire logic       TX_VALID,
   input  wire logic [8:0] TX_DATA,
   output logic            TX_READY,
   output logic            RX_VALID,
   output logic [8:0]      RX_DATA,
   output logic            RX_FRAME_ERR
);
   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   logic [10:0] tx_sh_q;
   logic [3:0]  tx_cnt_q, rx_cnt_q, len;
   logic [15:0] tx_tmr_q, rx_tmr_q;
   logic        tx_busy_q, rx_busy_q, in_prev_q;
   logic [8:0]  rx_sh_q;

   assign len = NINE_BIT ? uart_pkg::FRAME_LEN9 : uart_pkg::FRAME_LEN8;
   assign TX_READY = ~tx_busy_q;
   assign LINK.far_to_dev = tx_sh_q[0];

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         tx_sh_q <= 11'h7ff;
         tx_busy_q <= 1'b0;
         tx_cnt_q <= 4'h0;
         tx_tmr_q <= 16'h0000;
      end else if (!tx_busy_q) begin
         if (TX_VALID) begin
            // Address bytes carry ninth bit one
            tx_sh_q <= {1'b1, NINE_BIT ? TX_DATA[8] : 1'b1, TX_DATA[7:0], 1'b0};
            tx_busy_q <= 1'b1;
            tx_cnt_q <= 4'h0;
            tx_tmr_q <= 16'h0000;
         end
      end else if (tx_tmr_q == BIT_CYCLES - 16'h0001) begin
         tx_tmr_q <= 16'h0000;
         tx_sh_q <= {1'b1, tx_sh_q[10:1]};
         tx_cnt_q <= tx_cnt_q + 4'h1;
         if (tx_cnt_q == len - 4'h1) begin
            tx_busy_q <= 1'b0;
         end
      end else begin
         tx_tmr_q <= tx_tmr_q + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   // Timer starts at half a bit so samples land mid-bit
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         in_prev_q <= 1'b1;
         rx_busy_q <= 1'b0;
         rx_cnt_q <= 4'h0;
         rx_tmr_q <= 16'h0000;
         rx_sh_q <= 9'h000;
         RX_VALID <= 1'b0;
         RX_DATA <= 9'h000;
         RX_FRAME_ERR <= 1'b0;
      end else begin
         in_prev_q <= LINK.dev_to_far;
         RX_VALID <= 1'b0;
         if (!rx_busy_q) begin
            if (in_prev_q && !LINK.dev_to_far) begin
               rx_busy_q <= 1'b1;
               rx_cnt_q <= 4'h0;
               rx_tmr_q <= {1'b0, BIT_CYCLES[15:1]};
            end
         end else if (rx_tmr_q == BIT_CYCLES - 16'h0001) begin
            rx_tmr_q <= 16'h0000;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == 4'h0 && LINK.dev_to_far) begin
               rx_busy_q <= 1'b0;
            end else if (rx_cnt_q == len - 4'h1) begin
               rx_busy_q <= 1'b0;
               RX_VALID <= 1'b1;
               RX_DATA <= NINE_BIT ? rx_sh_q : {LINK.dev_to_far, rx_sh_q[8:1]};
               RX_FRAME_ERR <= ~LINK.dev_to_far;
            end else if (rx_cnt_q != 4'h0) begin
               rx_sh_q <= {LINK.dev_to_far, rx_sh_q[8:1]};
            end
         end else begin
            rx_tmr_q <= rx_tmr_q + 16'h0001;
         end
      end
   end
endmodule // uart_far

// ### verification/uart_chk.sv
`timescale 1ns/1ps
module uart_chk #(
   parameter logic [15:0] BIT_CYCLES = uart_pkg::FAR_BIT_CYCLES
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic dev_to_far,
   input wire logic far_to_dev
);
   // ---------------------------------------------------------------
   // Run-length counters
   // ---------------------------------------------------------------
   // High runs start saturated so the first frame after reset is not short
   localparam logic [15:0] LOW_MAX = BIT_CYCLES * 16'h000a;
   logic [15:0] dev_low_q;
   logic [15:0] far_low_q;
   logic [15:0] dev_high_q;
   logic [15:0] far_high_q;
   always_ff @(posedge CLK) begin
      if (SYS_RST || dev_to_far) dev_low_q <= 16'h0000;
      else dev_low_q <= dev_low_q + 16'h0001;
   end
   always_ff @(posedge CLK) begin
      if (SYS_RST || far_to_dev) far_low_q <= 16'h0000;
      else far_low_q <= far_low_q + 16'h0001;
   end
   always_ff @(posedge CLK) begin
      if (SYS_RST) dev_high_q <= 16'hffff;
      else if (!dev_to_far) dev_high_q <= 16'h0000;
      else if (dev_high_q != 16'hffff) dev_high_q <= dev_high_q + 16'h0001;
   end
   always_ff @(posedge CLK) begin
      if (SYS_RST) far_high_q <= 16'hffff;
      else if (!far_to_dev) far_high_q <= 16'h0000;
      else if (far_high_q != 16'hffff) far_high_q <= far_high_q + 16'h0001;
   end
   // ---------------------------------------------------------------
   // Wire properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   a_link_idle_reset: assert property ($fell(SYS_RST) |-> dev_to_far && far_to_dev)
      else $error("link not idle high after reset");
   a_dev_bit_grid: assert property ($rose(dev_to_far) |-> dev_low_q % BIT_CYCLES == 16'h0000)
      else $error("device low run not whole bits");
   a_far_bit_grid: assert property ($rose(far_to_dev) |-> far_low_q % BIT_CYCLES == 16'h0000)
      else $error("far low run not whole bits");
   a_dev_low_max: assert property (dev_low_q <= LOW_MAX)
      else $error("device line low too long");
   a_far_low_max: assert property (far_low_q <= LOW_MAX)
      else $error("far line low too long");
   a_dev_stop_min: assert property ($fell(dev_to_far) |-> dev_high_q >= BIT_CYCLES)
      else $error("device high run shorter than a bit");
   a_far_stop_min: assert property ($fell(far_to_dev) |-> far_high_q >= BIT_CYCLES)
      else $error("far high run shorter than a bit");
   a_dev_start_hold: assert property ($fell(dev_to_far) |-> !dev_to_far [*8])
      else $error("device low pulse too short");
   a_far_start_hold: assert property ($fell(far_to_dev) |-> !far_to_dev [*8])
      else $error("far low pulse too short");
endmodule // uart_chk

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   // Reload 0xf8 at divide by one gives 16 clocks a bit on both ends
   localparam logic [15:0] BIT = 16'h0010;
   logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        nine_bit, far_tx_valid, far_tx_ready, far_rx_valid, far_rx_err;
   logic [8:0]  far_tx_data, far_rx_data;
   int          errors, check_count;
   uart_link_if uart_link_if_inst ();
   uart_dev uart_dev_inst (.CLK(clk), .SYS_RST(sys_rst), .LINK(uart_link_if_inst.dev),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
   uart_far #(.BIT_CYCLES(BIT)) uart_far_inst (.CLK(clk), .SYS_RST(sys_rst),
      .LINK(uart_link_if_inst.far), .NINE_BIT(nine_bit), .TX_VALID(far_tx_valid),
      .TX_DATA(far_tx_data), .TX_READY(far_tx_ready), .RX_VALID(far_rx_valid),
      .RX_DATA(far_rx_data), .RX_FRAME_ERR(far_rx_err));
   uart_chk #(.BIT_CYCLES(BIT)) uart_chk_inst (.CLK(clk), .SYS_RST(sys_rst),
      .dev_to_far(uart_link_if_inst.dev_to_far), .far_to_dev(uart_link_if_inst.far_to_dev));
   always #20 clk = ~clk;
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic timeout(input string what);
      errors++;
      $display("Error at %0t: timeout waiting for %s", $time, what);
      print_verdict();
   endtask
   // Idle cycle first, so two transfers never assign psel in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Answer taken at the rising edge where pready is high, then released
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 100) timeout("pready");
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp, what);
   endtask
   task automatic far_send(input logic [8:0] d);
      int n;
      @(posedge clk);
      far_tx_valid <= 1'b1; far_tx_data <= d;
      for (n = 0; n < 2000; n++) begin
         @(negedge clk);
         if (far_tx_ready === 1'b1) break;
      end
      if (n == 2000) timeout("far ready");
      @(posedge clk);
      far_tx_valid <= 1'b0;
   endtask
   task automatic wait_far_rx(input logic [8:0] exp);
      int n;
      for (n = 0; n < 2000; n++) begin
         @(negedge clk);
         if (far_rx_valid === 1'b1) break;
      end
      if (n == 2000) timeout("far receive");
      chk({22'h0, far_rx_err, far_rx_data}, {23'h0, exp}, "far received frame");
   endtask
   // Waits out the far frame plus margin past the device stop sample
   task automatic idle_frame();
      int n;
      for (n = 0; n < 2000; n++) begin
         @(negedge clk);
         if (far_tx_ready === 1'b1) break;
      end
      if (n == 2000) timeout("far idle");
      repeat (40) @(posedge clk);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] q;
      logic        e;
      rd_chk(uart_pkg::OFS_CONTROL, {24'h0, uart_pkg::CONTROL_RESET}, "control reset");
      rd_chk(uart_pkg::OFS_RELOAD, 32'h0, "reload reset");
      rd_chk(uart_pkg::OFS_TIMER, 32'h0, "timer reset");
      apb(1'b0, 8'h10, 32'h0, q, e);
      chk({e, q[30:0]}, 32'h80000000, "unmapped read");
      wr(uart_pkg::OFS_RELOAD, 32'h000000f8);
      wr(uart_pkg::OFS_TIMER, 32'h00000009);
      rd_chk(uart_pkg::OFS_RELOAD, 32'h000000f8, "reload readback");
      $display("t_regs done");
   endtask
   task automatic t_tx8();
      int   n;
      logic last;
      wr(uart_pkg::OFS_CONTROL, 32'h00000010);
      wr(uart_pkg::OFS_BUFFER, 32'h00000025);
      last = 1'b1;
      for (n = 0; n < 2000; n++) begin
         @(negedge clk);
         if (irq === 1'b1) break;
         last = uart_link_if_inst.dev_to_far;
      end
      if (n == 2000) timeout("transmit flag");
      chk({30'h0, last, uart_link_if_inst.dev_to_far}, 32'h1, "flag at stop start");
      wait_far_rx(9'h125);
      repeat (60) @(posedge clk);
      rd_chk(uart_pkg::OFS_CONTROL, 32'h00000052, "flag held");
      wr(uart_pkg::OFS_CONTROL, 32'h00000010);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      $display("t_tx8 done");
   endtask
   task automatic t_rx8();
      wr(uart_pkg::OFS_BUFFER, 32'h000000c3);
      far_send(9'h03c);
      wait_far_rx(9'h1c3);
      idle_frame();
      chk({31'h0, irq}, 32'h1, "irq on flags");
      rd_chk(uart_pkg::OFS_CONTROL, 32'h00000057, "stop into ninth");
      rd_chk(uart_pkg::OFS_BUFFER, 32'h0000003c, "receive buffer");
      wr(uart_pkg::OFS_CONTROL, 32'h00000011);
      far_send(9'h099);
      idle_frame();
      rd_chk(uart_pkg::OFS_BUFFER, 32'h0000003c, "overrun keeps byte");
      rd_chk(uart_pkg::OFS_CONTROL, 32'h00000051, "overrun no load");
      wr(uart_pkg::OFS_CONTROL, 32'h00000000);
      far_send(9'h0aa);
      idle_frame();
      rd_chk(uart_pkg::OFS_CONTROL, 32'h00000040, "receiver off");
      wr(uart_pkg::OFS_CONTROL, 32'h00000030);
      far_send(9'h055);
      idle_frame();
      rd_chk(uart_pkg::OFS_CONTROL, 32'h00000075, "filtered stop one");
      rd_chk(uart_pkg::OFS_BUFFER, 32'h00000055, "filtered byte");
      $display("t_rx8 done");
   endtask
   task automatic t_nine();
      @(posedge clk);
      nine_bit <= 1'b1;
      wr(uart_pkg::OFS_CONTROL, 32'h00000098);
      wr(uart_pkg::OFS_BUFFER, 32'h0000005a);
      wait_far_rx(9'h15a);
      far_send(9'h081);
      idle_frame();
      rd_chk(uart_pkg::OFS_BUFFER, 32'h00000081, "nine bit data");
      rd_chk(uart_pkg::OFS_CONTROL, 32'h000000db, "ninth stored");
      wr(uart_pkg::OFS_CONTROL, 32'h000000b0);
      far_send(9'h011);
      idle_frame();
      rd_chk(uart_pkg::OFS_CONTROL, 32'h000000f0, "data byte filtered");
      far_send(9'h122);
      idle_frame();
      rd_chk(uart_pkg::OFS_CONTROL, 32'h000000f5, "address accepted");
      rd_chk(uart_pkg::OFS_BUFFER, 32'h00000022, "address byte");
      $display("t_nine done");
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; nine_bit = 1'b0; far_tx_valid = 1'b0;
      far_tx_data = 9'h000; errors = 0; check_count = 0;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_tx8();
      t_rx8();
      t_nine();
      print_verdict();
   end
endmodule // tb
